// File: core/wake_pkg.sv
// constants shared by the wake-up unit and its testbench
// Functional notes
// - forty wake inputs in five groups of eight, each with edge, pending, enable.
// - each input triggers on rising or falling edge as software selects.
// - a trigger sets the input's pending flag; it stays set until cleared.
// - idle entry is refused while any input is both enabled and pending.
// - wake request is OR of pending-and-enabled inputs, to power manager and interrupt unit.
// - wake request lets the power manager leave idle; interrupts signal edge events.
// - edge detection and pending setting keep working independent of core activity.
// - a disabled input's per-input interrupt output follows the raw input, inverted for the lpc reset input 39.
// - an enabled input's per-input interrupt output shows its pending flag.
// - no masking of per-input interrupt outputs inside this unit.
// - five group lines, each set by a trigger on an enabled input in its group.
// - every group has its own group line; all five groups also have per-input outputs.
// - host-access wake input is configured by software for rising edges.
// - lpc reset input: select 0 wakes on reset falling, 1 on rising.
// - edge select 0 means rising, 1 means falling; reset clears all selects.
// - software writes to pending can only set flags; writing 0 does nothing.
// - writing 1 to a pending-clear bit clears that flag; 0 does nothing.
// - reset clears every enable bit.
package wake_pkg;
    // ********************************************
    // geometry
    // ********************************************
    localparam int NUM_INPUTS = 40;
    localparam int GROUP_SIZE = 8;
    localparam int NUM_GROUPS = 5;
    localparam int ADDR_W = 12;
    localparam int LRESET_INPUT = 39;
    // ********************************************
    // register indices (byte address is four times the index)
    // ********************************************
    localparam logic [9:0] IDX_EDGE_BASE = 10'h1C0;
    localparam logic [9:0] IDX_PEND_BASE = 10'h1CA;
    localparam logic [9:0] IDX_CLR_BASE = 10'h1CC;
    localparam logic [9:0] IDX_EN_BASE = 10'h1DE;
    localparam logic [9:0] IDX_SINGLE_STEP = 10'h002;
    localparam logic [9:0] IDX_PAIR_STEP = 10'h004;
    localparam logic [9:0] IDX_STATUS = 10'h1E8;
    localparam int STAT_WAKE_BIT = 0;
    // ********************************************
    // reset values and bus answers
    // ********************************************
    localparam logic [7:0] EDGE_RST = 8'h00;
    localparam logic [7:0] EN_RST = 8'h00;
    localparam logic [7:0] PEND_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: core/wake_sync.sv
// two-flop synchroniser for the raw wake inputs
`timescale 1ns/1ps
module wake_sync #(
    parameter int WIDTH = 40
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // asynchronous level in, synchronised level out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_s;

    sync_state_s st_ff;
    sync_state_s nxt_st;

    // first stage is read only by the second stage
    always_comb begin
        nxt_st = st_ff;
        nxt_st.meta = async_in;
        nxt_st.stable = st_ff.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_out = st_ff.stable;
endmodule // wake_sync

// File: core/wake_edge.sv
// per-input edge detector with software-selected polarity
`timescale 1ns/1ps
module wake_edge #(
    parameter int WIDTH = 40
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // synchronised levels and polarity selects
    input wire logic [WIDTH-1:0] level,
    input wire logic [WIDTH-1:0] edge_sel,
    // one-cycle trigger pulses
    output logic [WIDTH-1:0] trig
);
    typedef struct packed {
        logic primed;
        logic [WIDTH-1:0] prev;
    } edge_state_s;

    edge_state_s st_ff;
    edge_state_s nxt_st;

    // primed blocks a false edge from the reset value of prev
    always_comb begin
        nxt_st = st_ff;
        nxt_st.prev = level;
        nxt_st.primed = 1'b1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // select 0 rising, select 1 falling
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign trig[i] = st_ff.primed & (edge_sel[i] ? (st_ff.prev[i] & ~level[i])
                                                         : (~st_ff.prev[i] & level[i]));
        end
    endgenerate
endmodule // wake_edge

// File: core/wake_unit.sv
// multi-input wake-up unit with AXI4-Lite register access
`timescale 1ns/1ps
module wake_unit
    import wake_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // wake inputs, input 39 is the lpc reset pin
    input wire logic [NUM_INPUTS-1:0] wake_input,
    // per-input and group interrupts to the interrupt unit
    output logic [NUM_INPUTS-1:0] per_input_irq_out,
    output logic group_irq_a,
    output logic group_irq_b,
    output logic group_irq_c,
    output logic group_irq_d,
    output logic group_irq_e,
    // power manager
    output logic wake_req,
    input wire logic idle_req,
    output logic idle_grant,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    typedef struct packed {
        logic [NUM_INPUTS-1:0] edge_sel;
        logic [NUM_INPUTS-1:0] enable;
        logic [NUM_INPUTS-1:0] pend;
        logic [NUM_INPUTS-1:0] irq_out;
        logic [NUM_GROUPS-1:0] grp;
        logic wake;
        logic aw_hold;
        logic [9:0] aw_idx;
        logic w_hold;
        logic [7:0] w_byte;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } wake_state_s;

    wake_state_s st_ff;
    wake_state_s nxt_st;
    logic [NUM_INPUTS-1:0] pin_level;
    logic [NUM_INPUTS-1:0] raw_sync;
    logic [NUM_INPUTS-1:0] trig;
    logic [NUM_INPUTS-1:0] sw_set;
    logic [NUM_INPUTS-1:0] sw_clr;
    logic [NUM_INPUTS-1:0] live;
    logic [9:0] ar_idx;
    logic do_write;

    // ********************************************
    // input conditioning
    // ********************************************
    // lpc reset is inverted so select 0 wakes on its falling edge
    always_comb begin
        pin_level = wake_input;
        pin_level[LRESET_INPUT] = ~wake_input[LRESET_INPUT];
    end

    wake_sync #(.WIDTH(NUM_INPUTS)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pin_level),
        .sync_out(raw_sync)
    );

    // detection runs every cycle regardless of enables or bus traffic
    wake_edge #(.WIDTH(NUM_INPUTS)) u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .level(raw_sync),
        .edge_sel(st_ff.edge_sel),
        .trig(trig)
    );

    // ********************************************
    // bus handshakes
    // ********************************************
    assign awready = !st_ff.aw_hold;
    assign wready = !st_ff.w_hold;
    assign arready = !st_ff.rvalid;
    assign ar_idx = araddr[ADDR_W-1:2];
    assign do_write = st_ff.aw_hold && st_ff.w_hold && !st_ff.bvalid;
    assign live = st_ff.pend & st_ff.enable;

    // ********************************************
    // next state
    // ********************************************
    always_comb begin
        logic hit;
        logic [9:0] g_idx;
        nxt_st = st_ff;
        sw_set = '0;
        sw_clr = '0;
        hit = 1'b0;
        g_idx = 10'h000;
        // address and data are taken in either order
        if (awvalid && awready) begin
            nxt_st.aw_hold = 1'b1;
            nxt_st.aw_idx = awaddr[ADDR_W-1:2];
        end
        if (wvalid && wready) begin
            nxt_st.w_hold = 1'b1;
            nxt_st.w_byte = wdata[7:0];
            nxt_st.w_lane0 = wstrb[0];
        end
        // register writes once both halves are held
        if (do_write) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                g_idx = 10'(g);
                if (st_ff.aw_idx == IDX_EDGE_BASE + IDX_SINGLE_STEP * g_idx) begin
                    hit = 1'b1;
                    if (st_ff.w_lane0) begin
                        nxt_st.edge_sel[g*GROUP_SIZE +: GROUP_SIZE] = st_ff.w_byte;
                    end
                end
                if (st_ff.aw_idx == IDX_EN_BASE + IDX_SINGLE_STEP * g_idx) begin
                    hit = 1'b1;
                    if (st_ff.w_lane0) begin
                        nxt_st.enable[g*GROUP_SIZE +: GROUP_SIZE] = st_ff.w_byte;
                    end
                end
                if (st_ff.aw_idx == IDX_PEND_BASE + IDX_PAIR_STEP * g_idx) begin
                    hit = 1'b1;
                    if (st_ff.w_lane0) begin
                        sw_set[g*GROUP_SIZE +: GROUP_SIZE] = st_ff.w_byte;
                    end
                end
                if (st_ff.aw_idx == IDX_CLR_BASE + IDX_PAIR_STEP * g_idx) begin
                    hit = 1'b1;
                    if (st_ff.w_lane0) begin
                        sw_clr[g*GROUP_SIZE +: GROUP_SIZE] = st_ff.w_byte;
                    end
                end
            end
            nxt_st.aw_hold = 1'b0;
            nxt_st.w_hold = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = hit ? RESP_OKAY : RESP_SLVERR;
        end else if (st_ff.bvalid && bready) begin
            nxt_st.bvalid = 1'b0;
        end
        // a trigger in the clearing cycle still leaves the flag set
        nxt_st.pend = ((st_ff.pend | sw_set) & ~sw_clr) | trig;
        // reads return pending, edge, enable or status; clear registers read zero
        if (arvalid && arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = 32'h0000_0000;
            nxt_st.rresp = RESP_SLVERR;
            for (int g = 0; g < NUM_GROUPS; g++) begin
                g_idx = 10'(g);
                if (ar_idx == IDX_EDGE_BASE + IDX_SINGLE_STEP * g_idx) begin
                    nxt_st.rdata[7:0] = st_ff.edge_sel[g*GROUP_SIZE +: GROUP_SIZE];
                    nxt_st.rresp = RESP_OKAY;
                end
                if (ar_idx == IDX_EN_BASE + IDX_SINGLE_STEP * g_idx) begin
                    nxt_st.rdata[7:0] = st_ff.enable[g*GROUP_SIZE +: GROUP_SIZE];
                    nxt_st.rresp = RESP_OKAY;
                end
                if (ar_idx == IDX_PEND_BASE + IDX_PAIR_STEP * g_idx) begin
                    nxt_st.rdata[7:0] = st_ff.pend[g*GROUP_SIZE +: GROUP_SIZE];
                    nxt_st.rresp = RESP_OKAY;
                end
                if (ar_idx == IDX_CLR_BASE + IDX_PAIR_STEP * g_idx) begin
                    nxt_st.rresp = RESP_OKAY;
                end
            end
            if (ar_idx == IDX_STATUS) begin
                nxt_st.rdata[STAT_WAKE_BIT] = st_ff.wake;
                nxt_st.rresp = RESP_OKAY;
            end
        end else if (st_ff.rvalid && rready) begin
            nxt_st.rvalid = 1'b0;
        end
        // outputs: no local mask, the interrupt unit masks them
        for (int i = 0; i < NUM_INPUTS; i++) begin
            nxt_st.irq_out[i] = st_ff.enable[i] ? st_ff.pend[i] : raw_sync[i];
        end
        for (int g = 0; g < NUM_GROUPS; g++) begin
            nxt_st.grp[g] = |live[g*GROUP_SIZE +: GROUP_SIZE];
        end
        nxt_st.wake = |live;
    end

    // ********************************************
    // state register
    // ********************************************
    // pending flags get a defined zero even though software must not rely on it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
            st_ff.edge_sel <= {NUM_GROUPS{EDGE_RST}};
            st_ff.enable <= {NUM_GROUPS{EN_RST}};
            st_ff.pend <= {NUM_GROUPS{PEND_RST}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ********************************************
    // outputs
    // ********************************************
    assign per_input_irq_out = st_ff.irq_out;
    assign group_irq_a = st_ff.grp[0];
    assign group_irq_b = st_ff.grp[1];
    assign group_irq_c = st_ff.grp[2];
    assign group_irq_d = st_ff.grp[3];
    assign group_irq_e = st_ff.grp[4];
    assign wake_req = st_ff.wake;
    // grant is combinational so a fresh pending flag blocks idle at once
    assign idle_grant = idle_req && !(|live);
    assign bvalid = st_ff.bvalid;
    assign bresp = st_ff.bresp;
    assign rvalid = st_ff.rvalid;
    assign rdata = st_ff.rdata;
    assign rresp = st_ff.rresp;

    // ********************************************
    // assertions
    // ********************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_wake_raise: assert property ((|live) |=> wake_req)
        else $error("wake request missing");
    a_wake_drop: assert property (!(|live) |=> !wake_req)
        else $error("wake request without live input");
    a_idle_refused: assert property ((|live) |-> !idle_grant)
        else $error("idle granted while pending");
    a_trig_sets: assert property ((|trig) |=> ((st_ff.pend & $past(trig)) == $past(trig)))
        else $error("trigger did not set pending");
    a_pend_sticky: assert property (!(|sw_clr) |=>
        ((st_ff.pend & $past(st_ff.pend)) == $past(st_ff.pend)))
        else $error("pending dropped without clear");
    a_bypass_raw: assert property (1'b1 |=>
        ((per_input_irq_out & ~$past(st_ff.enable)) == ($past(raw_sync) & ~$past(st_ff.enable))))
        else $error("bypass output differs from input");
    a_enabled_pend: assert property (1'b1 |=>
        ((per_input_irq_out & $past(st_ff.enable)) == ($past(st_ff.pend) & $past(st_ff.enable))))
        else $error("enabled output differs from pending");
    a_group_a: assert property (1'b1 |=> (group_irq_a == $past(|live[7:0])))
        else $error("group line a wrong");
    a_reset_enable: assert property ($rose(aresetn) |-> (st_ff.enable == '0))
        else $error("enable not cleared by reset");
    a_bresp_hold: assert property ((bvalid && !bready) |=> (bvalid && $stable(bresp)))
        else $error("write response dropped");

    // remaining group lines follow the same one-cycle register as line a
    a_group_b: assert property (1'b1 |=> (group_irq_b == $past(|live[15:8])))
        else $error("group line b wrong");
    a_group_c: assert property (1'b1 |=> (group_irq_c == $past(|live[23:16])))
        else $error("group line c wrong");
    a_group_d: assert property (1'b1 |=> (group_irq_d == $past(|live[31:24])))
        else $error("group line d wrong");
    a_group_e: assert property (1'b1 |=> (group_irq_e == $past(|live[39:32])))
        else $error("group line e wrong");

    // pending flags: software sets, software clears, a trigger that beats a clear; then idle grant with nothing live
    a_sw_set: assert property ((|sw_set) |=>
        ((st_ff.pend & $past(sw_set)) == $past(sw_set)))
        else $error("pending set had no effect");
    a_clear_works: assert property ((|(sw_clr & ~trig)) |=>
        ((st_ff.pend & $past(sw_clr & ~trig)) == '0))
        else $error("pending clear had no effect");
    a_set_wins: assert property ((|(trig & sw_clr)) |=>
        ((st_ff.pend & $past(trig)) == $past(trig)))
        else $error("clear beat a trigger");
    a_grant_free: assert property ((idle_req && !(|live)) |-> idle_grant)
        else $error("idle refused with nothing pending");

    // reset state, synchroniser latency and zero upper read data; the synchroniser check skips two edges after release
    a_edge_reset: assert property ($rose(aresetn) |->
        (st_ff.edge_sel == {NUM_GROUPS{EDGE_RST}}))
        else $error("edge selects not cleared by reset");
    a_out_reset: assert property ($rose(aresetn) |->
        (!wake_req && (per_input_irq_out == '0)))
        else $error("outputs not quiet after reset");
    a_sync_delay: assert property (($past(aresetn) && $past(aresetn, 2)) |->
        (raw_sync == $past(pin_level, 2)))
        else $error("synchroniser latency not two edges");
    a_rdata_upper: assert property (rvalid |-> (rdata[31:8] == 24'h000000))
        else $error("upper read data not zero");
endmodule // wake_unit

// File: testbench/pm_model.sv
// power manager model facing the wake unit's idle handshake
`timescale 1ns/1ps
module pm_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // command from the bench
    input wire logic idle_cmd,
    // idle handshake and wake request
    output logic idle_req,
    input wire logic idle_grant,
    input wire logic wake_req,
    // model state seen by the bench
    output logic in_idle
);
    // idle is entered only on a grant; a wake request always wins over a new entry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_req <= 1'b0;
            in_idle <= 1'b0;
        end else begin
            idle_req <= idle_cmd && !in_idle;
            if (wake_req) begin
                in_idle <= 1'b0;
            end else if (idle_req && idle_grant) begin
                in_idle <= 1'b1;
            end
        end
    end
endmodule // pm_model

// File: testbench/tb_top.sv
// self-checking bench for the wake unit
`timescale 1ns/1ps
module tb_top;
    import wake_pkg::*;
    logic aclk = 1'b0;
    logic aresetn, idle_cmd, idle_req, idle_grant, wake_req, in_idle;
    logic [NUM_INPUTS-1:0] wake_input, per_input_irq_out;
    logic group_irq_a, group_irq_b, group_irq_c, group_irq_d, group_irq_e;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, r;
    logic [3:0] wstrb;
    logic [2:0] awprot, arprot;
    logic [1:0] bresp, rresp;
    logic [4:0] grp;
    logic [9:0] exp_q[$];
    int err_total, cmp_count, seed;
    assign grp = {group_irq_e, group_irq_d, group_irq_c, group_irq_b, group_irq_a};
    // 200 MHz clock
    always #2.5 aclk = ~aclk;
    wake_unit dut (.aclk, .aresetn, .wake_input, .per_input_irq_out, .group_irq_a,
        .group_irq_b, .group_irq_c, .group_irq_d, .group_irq_e, .wake_req, .idle_req,
        .idle_grant, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready, .wdata,
        .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
        .rvalid, .rready, .rdata, .rresp);
    pm_model pm (.aclk, .aresetn, .idle_cmd, .idle_req, .idle_grant, .wake_req, .in_idle);
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 64) begin
            err_total++;
            $display("CHECK FAILED at %0t: bus answer never came", $time);
            final_report();
        end
    endtask
    function automatic logic [9:0] gi(input logic [9:0] base, input logic [9:0] st, input int g);
        return base + st * 10'(g);
    endfunction
    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && n < 64);
        bready <= 1'b0;
        tmo(n);
        chk(40'(bresp), 40'(er), "write response");
    endtask
    // read: the expected answer is noted for the monitor
    task automatic rd(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        exp_q.push_back({er, d});
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && n < 64);
        rready <= 1'b0;
        tmo(n);
    endtask
    // read monitor: oldest note against each accepted answer
    always @(posedge aclk) begin
        if (rvalid && rready && exp_q.size() > 0) begin
            chk(40'({rresp, rdata}), 40'({exp_q[0][9:8], 24'h000000, exp_q[0][7:0]}), "read");
            void'(exp_q.pop_front());
        end else if (rvalid && rready) begin
            err_total++;
            $display("CHECK FAILED at %0t: read answer with no request noted", $time);
        end
    end
    // pin change needs two sync edges, trigger, pending and output stages
    task automatic settle();
        repeat (8) @(posedge aclk);
    endtask
    task automatic clr_all();
        for (int g = 0; g < NUM_GROUPS; g++) wr(gi(IDX_CLR_BASE, IDX_PAIR_STEP, g), 8'hFF, RESP_OKAY);
    endtask
    // ****************************************
    // stimulus
    // ****************************************
    initial begin
        seed = 74;
        aresetn = 1'b0;
        wake_input = 40'h80_0000_0000; // lpc reset pin idles high, so no edge at start
        {idle_cmd, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, awprot, arprot} = '0;
        wstrb = 4'hF;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            rd(gi(IDX_EDGE_BASE, IDX_SINGLE_STEP, g), EDGE_RST, RESP_OKAY);
            rd(gi(IDX_EN_BASE, IDX_SINGLE_STEP, g), EN_RST, RESP_OKAY);
        end
        rd(10'h3FF, 8'h00, RESP_SLVERR);
        wr(10'h3FF, 8'h5A, RESP_SLVERR);
        $display("test reset values done");
        for (int g = 0; g < NUM_GROUPS; g++) wr(gi(IDX_EN_BASE, IDX_SINGLE_STEP, g), 8'hFF, RESP_OKAY);
        // a write with lane 0 off is answered but leaves the register alone
        wstrb <= 4'h0;
        wr(gi(IDX_EN_BASE, IDX_SINGLE_STEP, 0), 8'h00, RESP_OKAY);
        wstrb <= 4'hF;
        rd(gi(IDX_EN_BASE, IDX_SINGLE_STEP, 0), 8'hFF, RESP_OKAY);
        @(posedge aclk);
        for (int g = 0; g < NUM_GROUPS; g++) wake_input[g*8+g] <= 1'b1;
        settle();
        chk(40'(wake_req), 40'h1, "wake request");
        chk(40'(grp), 40'h1F, "group lines");
        chk(per_input_irq_out, 40'h10_0804_0201, "per-input outputs");
        rd(IDX_STATUS, 8'h01, RESP_OKAY);
        for (int g = 0; g < NUM_GROUPS; g++) begin
            rd(gi(IDX_PEND_BASE, IDX_PAIR_STEP, g), 8'(1 << g), RESP_OKAY);
        end
        idle_cmd <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(40'({idle_grant, in_idle}), 40'h0, "idle refused");
        clr_all();
        rd(gi(IDX_CLR_BASE, IDX_PAIR_STEP, 0), 8'h00, RESP_OKAY);
        rd(gi(IDX_PEND_BASE, IDX_PAIR_STEP, 3), 8'h00, RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk(40'({wake_req, in_idle}), 40'h1, "idle entered");
        idle_cmd <= 1'b0;
        wake_input[1] <= 1'b1;
        settle();
        chk(40'({wake_req, in_idle}), 40'h2, "idle left");
        clr_all();
        $display("test rising edges and idle done");
        wr(gi(IDX_EDGE_BASE, IDX_SINGLE_STEP, 1), 8'hFF, RESP_OKAY);
        rd(gi(IDX_EDGE_BASE, IDX_SINGLE_STEP, 1), 8'hFF, RESP_OKAY);
        @(posedge aclk);
        wake_input[9] <= 1'b0;
        wake_input[10] <= 1'b1;
        settle();
        rd(gi(IDX_PEND_BASE, IDX_PAIR_STEP, 1), 8'h02, RESP_OKAY);
        clr_all();
        wr(gi(IDX_PEND_BASE, IDX_PAIR_STEP, 2), 8'h00, RESP_OKAY);
        rd(gi(IDX_PEND_BASE, IDX_PAIR_STEP, 2), 8'h00, RESP_OKAY);
        wr(gi(IDX_PEND_BASE, IDX_PAIR_STEP, 2), 8'h81, RESP_OKAY);
        wr(gi(IDX_PEND_BASE, IDX_PAIR_STEP, 2), 8'h00, RESP_OKAY);
        rd(gi(IDX_PEND_BASE, IDX_PAIR_STEP, 2), 8'h81, RESP_OKAY);
        chk(40'(grp), 40'h04, "group c only");
        clr_all();
        $display("test falling edge and pending set done");
        wr(gi(IDX_EN_BASE, IDX_SINGLE_STEP, 3), 8'h00, RESP_OKAY);
        for (int k = 0; k < 6; k++) begin
            r = $random(seed);
            wake_input[31:24] <= r[7:0];
            repeat (5) @(posedge aclk);
            chk(40'(per_input_irq_out[31:24]), 40'(r[7:0]), "bypass");
        end
        chk(40'(wake_req), 40'h0, "disabled inputs never wake");
        clr_all();
        $display("test bypass done");
        wr(gi(IDX_EN_BASE, IDX_SINGLE_STEP, 4), 8'h80, RESP_OKAY);
        wake_input[39] <= 1'b0;
        settle();
        rd(gi(IDX_PEND_BASE, IDX_PAIR_STEP, 4), 8'h80, RESP_OKAY);
        chk(40'(grp), 40'h10, "group e");
        clr_all();
        wr(gi(IDX_EDGE_BASE, IDX_SINGLE_STEP, 4), 8'h80, RESP_OKAY);
        rd(gi(IDX_EDGE_BASE, IDX_SINGLE_STEP, 4), 8'h80, RESP_OKAY);
        wake_input[39] <= 1'b1;
        settle();
        rd(gi(IDX_PEND_BASE, IDX_PAIR_STEP, 4), 8'h80, RESP_OKAY);
        // pin change three edges before the clear lands: trigger and clear meet in one cycle
        wake_input[2] <= 1'b1;
        wr(gi(IDX_CLR_BASE, IDX_PAIR_STEP, 0), 8'h04, RESP_OKAY);
        rd(gi(IDX_PEND_BASE, IDX_PAIR_STEP, 0), 8'h04, RESP_OKAY);
        $display("test lpc reset input done");
        repeat (4) @(posedge aclk);
        final_report();
    end
endmodule // tb_top
